// [src/aks_key_setting.sv]
`timescale 1ns/1ps
`include "aks_defs.svh"
module aks_key_setting #(
   parameter int KEY_BYTES = 84
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Received byte stream
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   // Transmitted byte stream
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   // Device state
   input wire logic lifecycleAllows,
   input wire logic encWriteNoReset,
   input wire logic [1:0] authLevel,
   // Key wrap engine
   output logic wrapStart,
   output logic [7:0] keyKind,
   input wire logic [6:0] keyRdAddr,
   output logic [7:0] keyRdData,
   input wire logic wrapDone,
   input wire logic wrapFail,
   input wire logic secAbnormal,
   // Flash store engine
   output logic storeStart,
   input wire logic storeDone,
   input wire logic storeFail,
   input wire logic [31:0] flashStatus,
   // Silent after a security fault
   output logic halted
);

   if (KEY_BYTES != 84) begin : gParamCheck
      $error("KEY_BYTES must match the key packet layout");
   end

   aks_pkg::aks_state_type state_q;
   aks_pkg::aks_status_type resp_q;
   logic dataPhase_q;
   logic nextData_q;
   logic [15:0] len_q;
   logic [15:0] cnt_q;
   logic [7:0] sum_q;
   logic [7:0] opByte_q;
   logic [7:0] kindByte_q;
   logic endOk_q;
   logic [3:0] txIdx_q;
   logic [7:0] txSum_q;
   logic [7:0] keyMem [0:KEY_BYTES-1];
   logic rxTake;
   logic txMove;
   logic kindValid;
   logic kindAllowed;
   logic [7:0] startByte;

   assign rxTake = rxValid && (state_q inside {aks_pkg::S_HUNT, aks_pkg::S_LENH, aks_pkg::S_LENL,
                                               aks_pkg::S_BODY, aks_pkg::S_SUM, aks_pkg::S_END});
   assign txMove = txValid && txReady;
   assign startByte = dataPhase_q ? `AKS_DATA_START : `AKS_CMD_START;
   assign kindValid = (kindByte_q == `AKS_KEY_LEVEL_TWO) || (kindByte_q == `AKS_KEY_LEVEL_ONE)
                      || (kindByte_q == `AKS_KEY_RETURN_AUTH);
   assign kindAllowed = (authLevel == `AKS_AUTH_LEVEL_TWO)
                        || ((authLevel == `AKS_AUTH_LEVEL_ONE) && (kindByte_q == `AKS_KEY_LEVEL_ONE));

   // Frame capture: length, running sum, body bytes and end byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         len_q <= 16'h0000;
         cnt_q <= 16'h0000;
         sum_q <= 8'h00;
         opByte_q <= 8'h00;
         kindByte_q <= 8'h00;
         endOk_q <= 1'b0;
      end else if (rxTake) begin
         unique case (state_q)
            aks_pkg::S_HUNT: begin
               sum_q <= 8'h00;
               cnt_q <= 16'h0000;
            end
            aks_pkg::S_LENH: begin
               len_q[15:8] <= rxData;
               sum_q <= rxData;
            end
            aks_pkg::S_LENL: begin
               len_q[7:0] <= rxData;
               sum_q <= sum_q + rxData;
            end
            aks_pkg::S_BODY: begin
               sum_q <= sum_q + rxData;
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'h0000) begin
                  opByte_q <= rxData;
               end
               if ((cnt_q == 16'h0001) && !dataPhase_q) begin
                  kindByte_q <= rxData;
               end
            end
            aks_pkg::S_SUM: begin
               sum_q <= sum_q + rxData;
            end
            aks_pkg::S_END: begin
               endOk_q <= (rxData == `AKS_END_BYTE);
            end
            default: begin
            end
         endcase
      end
   end

   // Key bytes land in order as they arrive; the read port shows them before the packet is checked
   always_ff @(posedge ref_clk) begin
      if (rxTake && dataPhase_q && (state_q == aks_pkg::S_BODY) && (cnt_q != 16'h0000)
          && (cnt_q <= 16'(KEY_BYTES))) begin
         keyMem[7'(cnt_q - 16'h0001)] <= rxData;
      end
   end

   // Registered read port for the wrap engine
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         keyRdData <= 8'h00;
      end else if (32'(keyRdAddr) < KEY_BYTES) begin
         keyRdData <= keyMem[keyRdAddr];
      end else begin
         keyRdData <= 8'h00;
      end
   end

   // Main sequencer: framing, checks in priority order, wrap and store
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= aks_pkg::S_HUNT;
         dataPhase_q <= 1'b0;
         nextData_q <= 1'b0;
         resp_q <= '0;
         wrapStart <= 1'b0;
         storeStart <= 1'b0;
         keyKind <= 8'h00;
         halted <= 1'b0;
      end else begin
         wrapStart <= 1'b0;
         storeStart <= 1'b0;
         unique case (state_q)
            aks_pkg::S_HUNT: begin
               if (rxValid && (rxData == startByte)) begin
                  state_q <= aks_pkg::S_LENH;
               end
            end
            aks_pkg::S_LENH: begin
               if (rxValid) begin
                  state_q <= aks_pkg::S_LENL;
               end
            end
            aks_pkg::S_LENL: begin
               if (rxValid) begin
                  state_q <= ({len_q[15:8], rxData} == 16'h0000) ? aks_pkg::S_SUM : aks_pkg::S_BODY;
               end
            end
            aks_pkg::S_BODY: begin
               if (rxValid && (cnt_q == len_q - 16'h0001)) begin
                  state_q <= aks_pkg::S_SUM;
               end
            end
            aks_pkg::S_SUM: begin
               if (rxValid) begin
                  state_q <= aks_pkg::S_END;
               end
            end
            aks_pkg::S_END: begin
               if (rxValid) begin
                  state_q <= aks_pkg::S_EVAL;
               end
            end
            aks_pkg::S_EVAL: begin
               state_q <= aks_pkg::S_TX;
               nextData_q <= 1'b0;
               resp_q <= '{`AKS_RESP_ERR, `AKS_STS_PACKET, `AKS_UNUSED_WORD, `AKS_UNUSED_WORD};
               if (!endOk_q) begin
                  resp_q.statusCode <= `AKS_STS_PACKET;
               end else if (sum_q != 8'h00) begin
                  resp_q.statusCode <= `AKS_STS_CHECKSUM;
               end else if (len_q == 16'h0000) begin
                  resp_q.statusCode <= `AKS_STS_PACKET;
               end else if (!dataPhase_q) begin
                  if ((len_q != `AKS_CMD_LEN) || (opByte_q != `AKS_CMD_CODE)) begin
                     resp_q.statusCode <= `AKS_STS_PACKET;
                  end else if (!lifecycleAllows || encWriteNoReset) begin
                     resp_q.statusCode <= `AKS_STS_ACCEPT;
                  end else if (!kindValid) begin
                     resp_q.statusCode <= `AKS_STS_PARAM;
                  end else if (!kindAllowed) begin
                     resp_q.statusCode <= `AKS_STS_SECURE;
                  end else begin
                     resp_q <= '{`AKS_RESP_OK, `AKS_STS_OK, `AKS_UNUSED_WORD, `AKS_UNUSED_WORD};
                     keyKind <= kindByte_q;
                     nextData_q <= 1'b1;
                  end
               end else begin
                  if (len_q < `AKS_DATA_LEN) begin
                     resp_q.statusCode <= `AKS_STS_PACKET;
                  end else if (opByte_q != `AKS_RESP_OK) begin
                     resp_q.statusCode <= `AKS_STS_PACKET;
                  end else if (len_q > `AKS_DATA_LEN) begin
                     resp_q.statusCode <= `AKS_STS_PARAM;
                  end else begin
                     state_q <= aks_pkg::S_WRAP;
                     wrapStart <= 1'b1;
                  end
               end
            end
            aks_pkg::S_TX: begin
               if (txMove && (txIdx_q == `AKS_STAT_LAST_IDX)) begin
                  state_q <= aks_pkg::S_HUNT;
                  dataPhase_q <= nextData_q;
               end
            end
            aks_pkg::S_WRAP: begin
               if (wrapDone) begin
                  if (secAbnormal) begin
                     state_q <= aks_pkg::S_DEAD;
                     halted <= 1'b1;
                  end else if (wrapFail) begin
                     resp_q <= '{`AKS_RESP_ERR, `AKS_STS_TRUSTED, `AKS_UNUSED_WORD, `AKS_UNUSED_WORD};
                     nextData_q <= 1'b0;
                     state_q <= aks_pkg::S_TX;
                  end else begin
                     storeStart <= 1'b1;
                     state_q <= aks_pkg::S_STORE;
                  end
               end
            end
            aks_pkg::S_STORE: begin
               if (storeDone) begin
                  nextData_q <= 1'b0;
                  state_q <= aks_pkg::S_TX;
                  if (storeFail) begin
                     resp_q <= '{`AKS_RESP_ERR, `AKS_STS_FLASH, flashStatus, `AKS_UNUSED_WORD};
                  end else begin
                     resp_q <= '{`AKS_RESP_OK, `AKS_STS_OK, `AKS_UNUSED_WORD, `AKS_UNUSED_WORD};
                  end
               end
            end
            aks_pkg::S_DEAD: begin
               state_q <= aks_pkg::S_DEAD;
            end
         endcase
      end
   end

   // Status packet serialiser with running checksum
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txIdx_q <= 4'h0;
         txSum_q <= 8'h00;
         txValid <= 1'b0;
         txData <= 8'h00;
      end else if (state_q != aks_pkg::S_TX) begin
         txIdx_q <= 4'h0;
         txSum_q <= 8'h00;
         txValid <= 1'b0;
      end else if (!txValid || txMove) begin
         txValid <= !(txMove && (txIdx_q == `AKS_STAT_LAST_IDX)) || !txValid;
         if (txValid) begin
            txIdx_q <= txIdx_q + 4'h1;
         end
         unique case (txValid ? txIdx_q + 4'h1 : txIdx_q)
            4'h0: txData <= `AKS_DATA_START;
            4'h1: txData <= 8'h00;
            4'h2: txData <= `AKS_STAT_LEN;
            4'h3: txData <= resp_q.responseCode;
            4'h4: txData <= resp_q.statusCode;
            4'h5: txData <= resp_q.statusDetail[31:24];
            4'h6: txData <= resp_q.statusDetail[23:16];
            4'h7: txData <= resp_q.statusDetail[15:8];
            4'h8: txData <= resp_q.statusDetail[7:0];
            4'h9: txData <= resp_q.failAddr[31:24];
            4'ha: txData <= resp_q.failAddr[23:16];
            4'hb: txData <= resp_q.failAddr[15:8];
            4'hc: txData <= resp_q.failAddr[7:0];
            // Last address byte is still in flight, so fold it in here
            `AKS_STAT_SUM_IDX: txData <= 8'h00 - (txSum_q + txData);
            `AKS_STAT_LAST_IDX: txData <= `AKS_END_BYTE;
            default: txData <= 8'h00;
         endcase
         if (txValid && (txIdx_q >= 4'h1) && (txIdx_q < `AKS_STAT_SUM_IDX)) begin
            txSum_q <= txSum_q + txData;
         end
      end
   end

endmodule

// [src/aks_defs.svh]
`ifndef AKS_DEFS_SVH
`define AKS_DEFS_SVH

// Framing bytes
`define AKS_CMD_START 8'h01
`define AKS_DATA_START 8'h81
`define AKS_END_BYTE 8'h03
`define AKS_CMD_CODE 8'h28
`define AKS_RESP_OK 8'h28
`define AKS_RESP_ERR 8'ha8

// Expected lengths
`define AKS_CMD_LEN 16'h0002
`define AKS_DATA_LEN 16'h0055
`define AKS_STAT_LEN 8'h0a

// Key kinds
`define AKS_KEY_LEVEL_TWO 8'h01
`define AKS_KEY_LEVEL_ONE 8'h02
`define AKS_KEY_RETURN_AUTH 8'h03

// Authentication level codes on authLevel
`define AKS_AUTH_LEVEL_ONE 2'h1
`define AKS_AUTH_LEVEL_TWO 2'h2

// Status codes
`define AKS_STS_OK 8'h00
`define AKS_STS_PACKET 8'hc1
`define AKS_STS_CHECKSUM 8'hc2
`define AKS_STS_ACCEPT 8'hc3
`define AKS_STS_PARAM 8'hc4
`define AKS_STS_SECURE 8'hc5
`define AKS_STS_TRUSTED 8'hc6
`define AKS_STS_FLASH 8'hc7

// Status packet layout
`define AKS_UNUSED_WORD 32'hffffffff
`define AKS_STAT_LAST_IDX 4'he
`define AKS_STAT_SUM_IDX 4'hd

`endif

// [src/aks_pkg.sv]
package aks_pkg;

   // Receive and command sequencing states
   typedef enum logic [3:0] {
      S_HUNT, S_LENH, S_LENL, S_BODY, S_SUM, S_END, S_EVAL, S_TX, S_WRAP, S_STORE, S_DEAD
   } aks_state_type;

   // Contents of one outgoing status packet
   typedef struct packed {
      logic [7:0] responseCode;
      logic [7:0] statusCode;
      logic [31:0] statusDetail;
      logic [31:0] failAddr;
   } aks_status_type;

endpackage

// [sim/aks_key_setting_assertions.sv]
`timescale 1ns/1ps
// Port checks on the key setting block
module aks_key_setting_assertions #(
   parameter int KEY_BYTES = 84
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Byte streams
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txReady,
   // Engines
   input wire logic [6:0] keyRdAddr,
   input wire logic [7:0] keyRdData,
   input wire logic wrapStart,
   input wire logic wrapDone,
   input wire logic wrapFail,
   input wire logic secAbnormal,
   input wire logic storeStart,
   input wire logic halted
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Wrap outcomes
   sequence wrapGood;
      wrapDone && !wrapFail && !secAbnormal;
   endsequence
   sequence wrapBad;
      wrapDone && secAbnormal;
   endsequence
   tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply byte changed before accept");
   wrap_pulse_a: assert property (wrapStart |=> !wrapStart)
      else $error("wrap start longer than one cycle");
   store_after_a: assert property (wrapGood |=> storeStart)
      else $error("no store after good wrap");
   store_cause_a: assert property (storeStart |-> $past(wrapDone && !wrapFail && !secAbnormal))
      else $error("store without good wrap");
   halt_entry_a: assert property (wrapBad |=> halted)
      else $error("no halt after security fault");
   halt_stay_a: assert property (halted |=> halted)
      else $error("halt released");
   halt_quiet_a: assert property (halted |-> !txValid && !storeStart)
      else $error("activity while halted");
   key_range_a: assert property (keyRdAddr >= KEY_BYTES |=> keyRdData == 8'h00)
      else $error("key byte beyond end not zero");
endmodule

bind aks_key_setting aks_key_setting_assertions #(.KEY_BYTES(KEY_BYTES)) aks_chk_i (.ref_clk(ref_clk), .rst(rst),
   .txData(txData), .txValid(txValid), .txReady(txReady), .keyRdAddr(keyRdAddr), .keyRdData(keyRdData),
   .wrapStart(wrapStart), .wrapDone(wrapDone), .wrapFail(wrapFail), .secAbnormal(secAbnormal),
   .storeStart(storeStart), .halted(halted));

// [sim/aks_host_model.sv]
`timescale 1ns/1ps
// Host tool model: frames packets, collects reply bytes
module aks_host_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Host to device
   output logic [7:0] rxData,
   output logic rxValid,
   // Device to host
   input wire logic [7:0] txData,
   input wire logic txValid,
   output logic txReady
);
   logic slow;
   logic [7:0] got[$];
   // Idle link at time zero
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      txReady = 1'b0;
      slow = 1'b0;
   end
   // Key byte pattern, index 0 first on the wire
   function automatic logic [7:0] keyb(input int i);
      return 8'(i * 7 + 3);
   endfunction
   // One byte for one cycle
   task automatic put(input logic [7:0] b);
      rxData <= b;
      rxValid <= 1'b1;
      @(posedge ref_clk);
   endtask
   // Released line shows the inverse of the last byte
   task automatic idle();
      rxValid <= 1'b0;
      rxData <= ~rxData;
      @(posedge ref_clk);
   endtask
   // Framed packet: start, length, body, sum, end
   task automatic send(input logic [7:0] st, lenLo, b0, b1, adj, ending);
      logic [7:0] s;
      logic [7:0] b;
      s = lenLo;
      put(st);
      put(8'h00);
      put(lenLo);
      for (int j = 0; j < int'(lenLo); j++) begin
         b = (j == 0) ? b0 : ((j == 1 && st == 8'h01) ? b1 : keyb(j - 1));
         s = s + b;
         put(b);
      end
      put(8'h00 - s + adj);
      put(ending);
      idle();
   endtask
   // Collect replies, stalling every other cycle when slow
   always @(posedge ref_clk) begin
      if (txValid && txReady) got.push_back(txData);
      txReady <= slow ? ~txReady : 1'b1;
   end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "aks_defs.svh"
// Self-checking bench for the key setting block
module testbench;
   logic ref_clk, rst, rxValid, txValid, txReady, lifecycleAllows, encWriteNoReset, wrapStart, wrapDone;
   logic wrapFail, secAbnormal, storeStart, storeDone, storeFail, halted;
   logic [7:0] rxData, txData, keyKind, keyRdData;
   logic [1:0] authLevel;
   logic [6:0] keyRdAddr;
   logic [31:0] flashStatus;
   int err_total, checked, wraps;
   localparam logic [31:0] ONES = 32'hffffffff;
   int len_chk[4] = '{0, 35, 83, 84};
   aks_key_setting #(.KEY_BYTES(84)) aks_key_setting_i (.ref_clk(ref_clk), .rst(rst), .rxData(rxData),
      .rxValid(rxValid), .txData(txData), .txValid(txValid), .txReady(txReady), .lifecycleAllows(lifecycleAllows),
      .encWriteNoReset(encWriteNoReset), .authLevel(authLevel), .wrapStart(wrapStart), .keyKind(keyKind),
      .keyRdAddr(keyRdAddr), .keyRdData(keyRdData), .wrapDone(wrapDone), .wrapFail(wrapFail),
      .secAbnormal(secAbnormal), .storeStart(storeStart), .storeDone(storeDone), .storeFail(storeFail),
      .flashStatus(flashStatus), .halted(halted));
   aks_host_model aks_host_model_i (.ref_clk(ref_clk), .rst(rst), .rxData(rxData), .rxValid(rxValid),
      .txData(txData), .txValid(txValid), .txReady(txReady));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Engines finish one cycle after each start pulse
   always @(posedge ref_clk) begin
      wrapDone <= wrapStart;
      storeDone <= storeStart;
      if (wrapStart) wraps++;
   end
   task automatic cmp8(input logic [7:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] lenLo, code, kind, adj, ending);
      aks_host_model_i.send(8'h01, lenLo, code, kind, adj, ending);
   endtask
   // Wait for one status packet and compare all fifteen bytes
   task automatic status(input logic [7:0] res, sts, input logic [31:0] det);
      logic [7:0] e[15];
      int n;
      n = 0;
      while (aks_host_model_i.got.size() < 15 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      if (aks_host_model_i.got.size() < 15) begin
         err_total++;
         $display("MISMATCH %0t status packet timeout", $time);
         stop_test();
      end
      e = '{8'h81, 8'h00, 8'h0a, res, sts, det[31:24], det[23:16], det[15:8], det[7:0], 8'hff, 8'hff, 8'hff,
         8'hff, 8'h00, 8'h03};
      for (int i = 1; i < 13; i++) e[13] = e[13] - e[i];
      for (int i = 0; i < 15; i++) cmp8(aks_host_model_i.got[i], e[i], "status byte");
      aks_host_model_i.got.delete();
   endtask
   // Command packet faults and refusals
   task automatic t_cmd_errors();
      int w;
      w = wraps;
      cmd(8'h02, 8'h28, 8'h01, 8'h00, 8'h04);
      status(8'ha8, `AKS_STS_PACKET, ONES);
      cmd(8'h02, 8'h28, 8'h01, 8'h01, 8'h03);
      status(8'ha8, `AKS_STS_CHECKSUM, ONES);
      cmd(8'h03, 8'h28, 8'h01, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_PACKET, ONES);
      cmd(8'h02, 8'h29, 8'h01, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_PACKET, ONES);
      cmd(8'h02, 8'h28, 8'h04, 8'h01, 8'h03);
      status(8'ha8, `AKS_STS_CHECKSUM, ONES);
      lifecycleAllows <= 1'b0;
      cmd(8'h02, 8'h28, 8'h01, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_ACCEPT, ONES);
      lifecycleAllows <= 1'b1;
      encWriteNoReset <= 1'b1;
      cmd(8'h02, 8'h28, 8'h04, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_ACCEPT, ONES);
      encWriteNoReset <= 1'b0;
      cmd(8'h02, 8'h28, 8'h04, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_PARAM, ONES);
      authLevel <= `AKS_AUTH_LEVEL_ONE;
      cmd(8'h02, 8'h28, 8'h01, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_SECURE, ONES);
      cmd(8'h02, 8'h28, 8'h03, 8'h00, 8'h03);
      status(8'ha8, `AKS_STS_SECURE, ONES);
      cmp8(8'(wraps - w), 8'h00, "wrap count");
      $display("test cmd_errors done");
   endtask
   // Accepted commands followed by faulty key packets
   task automatic t_data_errors();
      logic [7:0] len[5] = '{8'h55, 8'h55, 8'h55, 8'h56, 8'h54};
      logic [7:0] res[5] = '{8'h28, 8'h28, 8'h29, 8'h28, 8'h28};
      logic [7:0] sts[5] = '{`AKS_STS_PACKET, `AKS_STS_CHECKSUM, `AKS_STS_PACKET, `AKS_STS_PARAM, `AKS_STS_PACKET};
      int w;
      w = wraps;
      authLevel <= `AKS_AUTH_LEVEL_TWO;
      for (int i = 0; i < 5; i++) begin
         cmd(8'h02, 8'h28, 8'(i % 3 + 1), 8'h00, 8'h03);
         status(8'h28, 8'h00, ONES);
         aks_host_model_i.put(8'h01);
         aks_host_model_i.send(8'h81, len[i], res[i], 8'h00, 8'(i == 1), (i == 0) ? 8'h04 : 8'h03);
         status(8'ha8, sts[i], ONES);
      end
      cmp8(8'(wraps - w), 8'h00, "wrap count");
      $display("test data_errors done");
   endtask
   // Full key setting with wrap and store outcomes, host stalling
   task automatic t_good();
      aks_host_model_i.slow = 1'b1;
      authLevel <= `AKS_AUTH_LEVEL_ONE;
      for (int k = 0; k < 3; k++) begin
         aks_host_model_i.put(8'h81);
         cmd(8'h02, 8'h28, 8'h02, 8'h00, 8'h03);
         status(8'h28, 8'h00, ONES);
         cmp8(keyKind, 8'h02, "key kind");
         wrapFail <= (k == 1);
         storeFail <= (k == 2);
         flashStatus <= 32'h0bad_0123;
         aks_host_model_i.send(8'h81, 8'h55, 8'h28, 8'h00, 8'h00, 8'h03);
         foreach (len_chk[j]) begin
            keyRdAddr <= 7'(len_chk[j]);
            @(posedge ref_clk);
            @(posedge ref_clk);
            cmp8(keyRdData, (j < 3) ? aks_host_model_i.keyb(len_chk[j]) : 8'h00, "key byte");
         end
         if (k == 0) status(8'h28, 8'h00, ONES);
         else if (k == 1) status(8'ha8, `AKS_STS_TRUSTED, ONES);
         else status(8'ha8, `AKS_STS_FLASH, 32'h0bad_0123);
      end
      wrapFail <= 1'b0;
      storeFail <= 1'b0;
      $display("test good done");
   endtask
   // Security fault after wrap silences the block until reset
   task automatic t_halt();
      secAbnormal <= 1'b1;
      cmd(8'h02, 8'h28, 8'h02, 8'h00, 8'h03);
      status(8'h28, 8'h00, ONES);
      aks_host_model_i.send(8'h81, 8'h55, 8'h28, 8'h00, 8'h00, 8'h03);
      cmd(8'h02, 8'h28, 8'h02, 8'h00, 8'h03);
      repeat (300) @(posedge ref_clk);
      cmp8(8'(aks_host_model_i.got.size()), 8'h00, "reply while halted");
      cmp8({7'h00, halted}, 8'h01, "halted");
      rst <= 1'b1;
      secAbnormal <= 1'b0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      cmp8({7'h00, halted}, 8'h00, "halted after reset");
      $display("test halt done");
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      lifecycleAllows = 1'b1;
      encWriteNoReset = 1'b0;
      authLevel = `AKS_AUTH_LEVEL_TWO;
      keyRdAddr = 7'h00;
      wrapDone = 1'b0;
      wrapFail = 1'b0;
      secAbnormal = 1'b0;
      storeDone = 1'b0;
      storeFail = 1'b0;
      flashStatus = 32'h0000_0000;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_cmd_errors();
      t_data_errors();
      t_good();
      t_halt();
      stop_test();
   end
endmodule
